// [include/sdio_ceata_pkg.sv]
// shared constants for the stall and task file command block
package sdio_ceata_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [4:0] OFF_CONTROL = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_BLOCK_LEN = 5'h08;
  localparam logic [4:0] OFF_XFER_LEN = 5'h0C;
  localparam logic [4:0] OFF_ARGUMENT = 5'h10;
  localparam logic [4:0] OFF_COMMAND = 5'h14;
  localparam logic [4:0] OFF_RESPONSE = 5'h18;
  // ==========================================================================
  // control and status bits
  localparam int CTL_STALL = 0;
  localparam int ST_DONE = 0;
  localparam int ST_CRC_ERR = 1;
  localparam int ST_TIMEOUT = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_STALLING = 4;
  localparam int ST_DATA_PEND = 5;
  // ==========================================================================
  // command_control fields
  localparam int CMD_INDEX_LSB = 0;
  localparam int CMD_INDEX_W = 6;
  localparam int CMD_RESP_EXP = 6;
  localparam int CMD_RESP_LONG = 7;
  localparam int CMD_CHK_CRC = 8;
  localparam int CMD_DATA_EXP = 9;
  localparam int CMD_WRITE = 10;
  localparam int CMD_STREAM = 11;
  localparam int CMD_AUTO_STOP = 12;
  localparam int CMD_WAIT_PRV = 13;
  localparam int CMD_STOP_ABORT = 14;
  localparam int CMD_SEND_INIT = 15;
  localparam int CMD_CLK_ONLY = 21;
  localparam int CMD_READ_ATA = 22;
  localparam int CMD_CCS_EXP = 23;
  localparam int CMD_START = 31;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // ==========================================================================
  // link framing
  localparam logic [7:0] CMD_FRAME_BITS = 8'h30;
  localparam logic [7:0] SHORT_RESP_BITS = 8'h30;
  localparam logic [7:0] LONG_RESP_BITS = 8'h88;
  localparam logic [7:0] RESP_TIMEOUT_CLKS = 8'h40;
  localparam logic [1:0] CMD_PREFIX = 2'h1;
  localparam logic [6:0] CRC7_POLY = 7'h09;
endpackage

// [include/cmd_if.sv]
// command hand-off between register front end and link engine
`timescale 1ns/10ps
interface cmd_if;
  logic start;
  logic [31:0] argument;
  logic [5:0] index;
  logic respExp;
  logic respLong;
  logic chkCrc;
  logic busy;
  logic done;
  logic crcErr;
  logic timeout;
  logic [31:0] response;
  modport front (output start, argument, index, respExp, respLong, chkCrc,
                 input busy, done, crcErr, timeout, response);
  modport engine (input start, argument, index, respExp, respLong, chkCrc,
                  output busy, done, crcErr, timeout, response);
endinterface

// [rtl/cmd_engine.sv]
// serial command sender and response receiver on the card link
`timescale 1ns/10ps
module cmd_engine import sdio_ceata_pkg::*; (
  input wire logic sys_clk,
  input wire logic rstn,
  cmd_if.engine cif,
  input wire logic cardClk,
  input wire logic cmdIn,
  output logic cmdOut_q,
  output logic cmdOe_q
);
  typedef enum logic [2:0] {
    IDLE = 3'b000, SEND = 3'b001, RWAIT = 3'b011, RECV = 3'b010, FIN = 3'b110
  } state_t;

  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = '0;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ CRC7_POLY;
      end
    end
    return c;
  endfunction

  // ==========================================================================
  // link sampling
  logic [1:0] clkS_q, cmdS_q;
  logic clkPrev_q;
  always_ff @(posedge sys_clk) begin
    clkS_q <= {clkS_q[0], cardClk};
    cmdS_q <= {cmdS_q[0], cmdIn};
    clkPrev_q <= clkS_q[1];
  end
  wire linkRise = clkS_q[1] & ~clkPrev_q;
  wire linkFall = ~clkS_q[1] & clkPrev_q;
  wire cmdBit = cmdS_q[1];

  // ==========================================================================
  // frame engine
  state_t state_q;
  logic [47:0] shift_q, rsp_q;
  logic [7:0] cnt_q;
  logic long_q, chk_q, exp_q, done_q, crcErr_q, timeout_q;
  wire [39:0] frameHead = {CMD_PREFIX, cif.index, cif.argument};
  wire crcBad = crc7(rsp_q[47:8]) != rsp_q[7:1];

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= IDLE;
      shift_q <= '0;
      rsp_q <= '0;
      cnt_q <= '0;
      {long_q, chk_q, exp_q, done_q, crcErr_q, timeout_q} <= '0;
      cmdOut_q <= 1'b1;
      cmdOe_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        IDLE: if (cif.start) begin
          shift_q <= {frameHead, crc7(frameHead), 1'b1};
          cnt_q <= CMD_FRAME_BITS;
          {long_q, chk_q, exp_q} <= {cif.respLong, cif.chkCrc, cif.respExp};
          state_q <= SEND;
        end
        SEND: if (linkFall) begin
          if (cnt_q != 8'h00) begin
            cmdOe_q <= 1'b1;
            cmdOut_q <= shift_q[47];
            shift_q <= {shift_q[46:0], 1'b0};
            cnt_q <= cnt_q - 8'h01;
          end else begin
            cmdOe_q <= 1'b0;
            cmdOut_q <= 1'b1;
            cnt_q <= RESP_TIMEOUT_CLKS;
            state_q <= exp_q ? RWAIT : FIN;
          end
        end
        RWAIT: if (linkRise) begin
          if (!cmdBit) begin
            rsp_q <= '0;
            cnt_q <= (long_q ? LONG_RESP_BITS : SHORT_RESP_BITS) - 8'h01;
            state_q <= RECV;
          end else if (cnt_q == 8'h01) begin
            timeout_q <= 1'b1;
            state_q <= FIN;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        RECV: if (linkRise) begin
          rsp_q <= {rsp_q[46:0], cmdBit};
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            state_q <= FIN;
          end
        end
        FIN: begin
          // long frames carry their own inner check, so only short ones are tested
          crcErr_q <= exp_q & ~timeout_q & chk_q & ~long_q & crcBad;
          done_q <= 1'b1;
          state_q <= IDLE;
        end
        default: state_q <= IDLE;
      endcase
      if (state_q == IDLE && cif.start) begin
        {crcErr_q, timeout_q} <= 2'b00;
      end
    end
  end

  assign cif.busy = state_q != IDLE;
  assign cif.done = done_q;
  assign cif.crcErr = crcErr_q;
  assign cif.timeout = timeout_q;
  assign cif.response = rsp_q[39:8];

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence sTaken;
    state_q == IDLE && cif.start;
  endsequence
  a_crc_skipped: assert property (done_q && !chk_q |-> !crcErr_q)
    else $error("crc error flagged with check off");
  a_crc_checked: assert property (state_q == FIN && exp_q && chk_q && !long_q && !timeout_q
    && crcBad |=> done_q && crcErr_q)
    else $error("bad response crc not flagged");
  sequence sFirstFall;
    state_q == SEND && cnt_q == CMD_FRAME_BITS && linkFall;
  endsequence
  a_frame_load: assert property (sTaken |=> state_q == SEND && cnt_q == CMD_FRAME_BITS)
    else $error("command not loaded into frame shifter");
  a_frame_start: assert property (sFirstFall |=> cmdOe_q && !cmdOut_q)
    else $error("command frame does not open with start bit");
endmodule

// [rtl/sdio_ceata_cmd.sv]
// register front end, stall signalling and task file command issue
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module sdio_ceata_cmd import sdio_ceata_pkg::*; (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cardClk,
  input wire logic cmdIn,
  output logic cmdOut_q,
  output logic cmdOe_q,
  output logic dat2Out_q,
  output logic dat2Oe_q,
  input wire logic dataOver,
  output logic xferStart_q,
  output logic xferWrite_q,
  output logic xferReadAta_q,
  output logic xferSingle_q,
  output logic [15:0] xferBlockLen_q,
  output logic [31:0] xferBytes_q
);
  cmd_if cif ();

  // ==========================================================================
  // registers
  logic [31:0] control_q, argument_q, command_q, blockLen_q, xferLen_q, response_q;
  logic [2:0] sticky_q;
  logic dataPending_q, issue_q, waitReq_q;
  logic [31:0] rdMux;

  wire req = avs_read | avs_write;
  wire access = req & ~waitReq_q;
  wire wrAcc = access & avs_write;
  wire wrCtl = wrAcc && avs_address == OFF_CONTROL;
  wire wrSts = wrAcc && avs_address == OFF_STATUS;
  wire wrBlk = wrAcc && avs_address == OFF_BLOCK_LEN;
  wire wrLen = wrAcc && avs_address == OFF_XFER_LEN;
  wire wrArg = wrAcc && avs_address == OFF_ARGUMENT;
  // a pending command cannot be rewritten until the engine has taken it
  wire wrCmd = wrAcc && avs_address == OFF_COMMAND && !command_q[CMD_START];
  wire holdPrev = command_q[CMD_WAIT_PRV] & dataPending_q;
  wire issue = command_q[CMD_START] & ~issue_q & ~cif.busy & ~holdPrev;
  wire doneOk = cif.done & ~cif.crcErr & ~cif.timeout;
  wire [2:0] stickySet = {cif.done & cif.timeout, cif.done & cif.crcErr, cif.done};
  wire [2:0] stickyClr = wrSts ? avs_writedata[ST_TIMEOUT:ST_DONE] : 3'h0;

  always_comb begin
    if (avs_address == OFF_CONTROL) begin
      rdMux = control_q;
    end else if (avs_address == OFF_STATUS) begin
      rdMux = {26'h0, dataPending_q, dat2Oe_q, cif.busy | issue_q, sticky_q};
    end else if (avs_address == OFF_BLOCK_LEN) begin
      rdMux = blockLen_q;
    end else if (avs_address == OFF_XFER_LEN) begin
      rdMux = xferLen_q;
    end else if (avs_address == OFF_ARGUMENT) begin
      rdMux = argument_q;
    end else if (avs_address == OFF_COMMAND) begin
      rdMux = command_q;
    end else if (avs_address == OFF_RESPONSE) begin
      rdMux = response_q;
    end else begin
      rdMux = 32'h0000_0000;
    end
  end

  // ==========================================================================
  // bus slave: one wait cycle, then the access lands
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      waitReq_q <= 1'b1;
      avs_readdata <= REG_RESET;
    end else begin
      waitReq_q <= ~(req & waitReq_q);
      if (req & waitReq_q) begin
        avs_readdata <= rdMux;
      end
    end
  end
  assign avs_waitrequest = waitReq_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      control_q <= REG_RESET;
      argument_q <= REG_RESET;
      blockLen_q <= REG_RESET;
      xferLen_q <= REG_RESET;
      response_q <= REG_RESET;
    end else begin
      if (wrCtl) control_q <= avs_writedata & (32'h1 << CTL_STALL);
      if (wrBlk) blockLen_q <= avs_writedata;
      if (wrLen) xferLen_q <= avs_writedata;
      if (wrArg) argument_q <= avs_writedata;
      if (cif.done) response_q <= cif.response;
    end
  end

  // ==========================================================================
  // command issue
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      command_q <= REG_RESET;
      issue_q <= 1'b0;
      sticky_q <= '0;
      dataPending_q <= 1'b0;
    end else begin
      issue_q <= issue;
      if (wrCmd) begin
        command_q <= avs_writedata;
      end else if (issue) begin
        command_q[CMD_START] <= 1'b0;
      end
      sticky_q <= (sticky_q & ~stickyClr) | stickySet;
      // a new data command wins over a data-over pulse in the same cycle
      if (issue & command_q[CMD_DATA_EXP]) begin
        dataPending_q <= 1'b1;
      end else if (dataOver) begin
        dataPending_q <= 1'b0;
      end
    end
  end

  assign cif.start = issue_q;
  assign cif.argument = argument_q;
  assign cif.index = command_q[CMD_INDEX_LSB +: CMD_INDEX_W];
  assign cif.respExp = command_q[CMD_RESP_EXP];
  assign cif.respLong = command_q[CMD_RESP_LONG];
  assign cif.chkCrc = command_q[CMD_CHK_CRC];

  cmd_engine engine (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .cif(cif),
    .cardClk(cardClk),
    .cmdIn(cmdIn),
    .cmdOut_q(cmdOut_q),
    .cmdOe_q(cmdOe_q)
  );

  // ==========================================================================
  // data hand-off and stall
  logic [31:0] issuedCmd_q;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      issuedCmd_q <= REG_RESET;
      xferStart_q <= 1'b0;
      xferWrite_q <= 1'b0;
      xferReadAta_q <= 1'b0;
      xferSingle_q <= 1'b0;
      xferBlockLen_q <= '0;
      xferBytes_q <= '0;
      dat2Out_q <= 1'b0;
      dat2Oe_q <= 1'b0;
    end else begin
      if (issue) issuedCmd_q <= command_q;
      // completion signal is never awaited: data starts right after the response
      xferStart_q <= doneOk & issuedCmd_q[CMD_DATA_EXP];
      if (doneOk) begin
        xferWrite_q <= issuedCmd_q[CMD_WRITE];
        xferReadAta_q <= issuedCmd_q[CMD_READ_ATA];
        xferBlockLen_q <= blockLen_q[15:0];
        xferBytes_q <= xferLen_q;
        // task file goes out as one block when byte count equals block length
        xferSingle_q <= xferLen_q == blockLen_q;
      end
      // stall holds the shared data line low whenever the stall bit is set; card capability is not checked
      dat2Out_q <= 1'b0;
      dat2Oe_q <= control_q[CTL_STALL];
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_stall_follow: assert property (dat2Oe_q == $past(control_q[CTL_STALL]))
    else $error("stall line does not follow stall bit");
  a_stall_low: assert property (dat2Oe_q |-> !dat2Out_q)
    else $error("stall line not driven low");
  a_prev_hold: assert property (holdPrev |=> !issue_q)
    else $error("command issued while previous data pending");
  a_prev_free: assert property (command_q[CMD_START] && !issue_q && !cif.busy
    && !holdPrev |=> issue_q)
    else $error("immediate command not issued");
  a_single_block: assert property (doneOk |=> xferSingle_q == ($past(xferLen_q)
    == $past(blockLen_q)))
    else $error("single block flag wrong");
  a_no_ccs_wait: assert property (doneOk && issuedCmd_q[CMD_DATA_EXP] |=> xferStart_q)
    else $error("data start delayed after response");
  a_bus_answer: assert property (req && waitReq_q |=> !waitReq_q ##1 waitReq_q)
    else $error("bus answer timing wrong");
endmodule

// [verif/card_model.sv]
// behavioural card that answers commands on the command line
`timescale 1ns/10ps
module card_model import sdio_ceata_pkg::*; (
  input wire logic cardClk,
  input wire logic cmdLine,
  input wire logic badCrc,
  input wire logic mute,
  output logic cardDrv,
  output logic cardOe,
  output logic [47:0] lastCmd
);
  logic [47:0] rx = '0;
  logic [47:0] tx = '0;
  int rc = 0;
  int tc = 0;
  // starts in transfer state at 512 byte blocks; no renegotiation modelled
  localparam logic [5:0] IO_IDX = 6'h34;
  // common register byte at offset 0x8: bit 2 set, every function takes a stall
  localparam logic [7:0] CAPS_BYTE = 8'h04;
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = '0;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
    end
    return c;
  endfunction
  initial begin
    cardDrv = 1'b1;
    cardOe = 1'b0;
    lastCmd = '0;
  end
  // ==========================================================================
  // capture on rising edges; answer echoes index and argument, except an IO_IDX read of offset 0x8 returns CAPS_BYTE in the low byte
  always @(posedge cardClk) begin
    if (tc == 0 && (rc > 0 || cmdLine == 1'b0)) begin
      rx = {rx[46:0], cmdLine};
      rc++;
    end
    if (rc == 48) begin
      rc = 0;
      lastCmd = rx;
      tx[47:8] = {2'b00, rx[45:40], rx[39:8]};
      if (rx[45:40] == IO_IDX && rx[33:17] == 17'h0_0008)
        tx[15:8] = CAPS_BYTE;
      tx[7:0] = {crc7(tx[47:8]) ^ {6'h00, badCrc}, 1'b1};
      tc = mute ? 0 : 50;
    end
  end
  // ==========================================================================
  // two idle clocks of turnaround, then 48 bits on falling edges
  always @(negedge cardClk) begin
    if (tc > 0) begin
      tc--;
      cardOe = (tc < 48);
      cardDrv = (tc < 48) ? tx[tc] : ~cardDrv;
    end else begin
      cardOe = 1'b0;
      cardDrv = ~cardDrv;
    end
  end
endmodule

// [verif/sdio_ceata_cmd_tb.sv]
// self-checking bench for the stall and task file command block
`timescale 1ns/10ps
module sdio_ceata_cmd_tb import sdio_ceata_pkg::*;;
  typedef struct packed {
    logic [4:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } row_t;
  localparam logic [5:0] TASK_IDX = 6'h3C;
  localparam logic [31:0] TF_ARG = 32'h8000_0010;
  // direct read of the card's common register at offset 0x8
  localparam logic [31:0] IO_ARG = 32'h0000_1000;
  // start, crc check, short response, no data, index 52
  localparam logic [31:0] IO_CMD = 32'h8000_0174;
  logic sys_clk = 1'b0;
  logic cardClk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic dataOver = 1'b0;
  logic badCrc = 1'b0;
  logic mute = 1'b0;
  logic [31:0] avs_readdata, q, c2;
  logic avs_waitrequest, cmdOut_q, cmdOe_q, dat2Out_q, dat2Oe_q, cardDrv, cardOe, cmdLine;
  logic xferStart_q, xferWrite_q, xferReadAta_q, xferSingle_q;
  logic [15:0] xferBlockLen_q;
  logic [31:0] xferBytes_q;
  logic [47:0] lastCmd;
  int num_errors = 0;
  int n_tests = 0;
  int nStart = 0;
  int cyc = 0;
  row_t rows [8] = '{'{OFF_BLOCK_LEN, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
    '{OFF_XFER_LEN, 32'hA5A5_5A5A, 32'hA5A5_5A5A}, '{OFF_ARGUMENT, 32'h5A5A_A5A5, 32'h5A5A_A5A5},
    '{OFF_COMMAND, 32'h00E0_FFFF, 32'h00E0_FFFF}, '{OFF_CONTROL, 32'hFFFF_FFFE, 32'h0},
    '{5'h1C, 32'h1234_5678, 32'h0}, '{5'h02, 32'hFFFF_FFFF, 32'h0},
    '{OFF_RESPONSE, 32'hFFFF_FFFF, 32'h0}};
  // pull-up holds the command line high when nobody drives it
  assign cmdLine = cmdOe_q ? cmdOut_q : (cardOe ? cardDrv : 1'b1);
  always #12.5 sys_clk = ~sys_clk;
  always #100 cardClk = ~cardClk;
  sdio_ceata_cmd i_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cardClk(cardClk),
    .cmdIn(cmdLine), .cmdOut_q(cmdOut_q), .cmdOe_q(cmdOe_q), .dat2Out_q(dat2Out_q),
    .dat2Oe_q(dat2Oe_q), .dataOver(dataOver), .xferStart_q(xferStart_q),
    .xferWrite_q(xferWrite_q), .xferReadAta_q(xferReadAta_q), .xferSingle_q(xferSingle_q),
    .xferBlockLen_q(xferBlockLen_q), .xferBytes_q(xferBytes_q));
  card_model i_card (.cardClk(cardClk), .cmdLine(cmdLine), .badCrc(badCrc), .mute(mute),
    .cardDrv(cardDrv), .cardOe(cardOe), .lastCmd(lastCmd));
  // ==========================================================================
  // helpers
  task end_sim;
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic [4:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check(n, 2);
  endtask
  task waitBit(input int b);
    int n;
    n = 0;
    q = '0;
    while (q[b] !== 1'b1 && n < 600) begin
      bus(OFF_STATUS, 1'b0, 32'h0, q);
      n++;
    end
    check(q[b], 1'b1);
  endtask
  // fields from bit 31 down: start, ata read, wait previous, write, data, crc, resp, index
  function automatic logic [31:0] cmdWord(input logic wr, ata, crc, wp);
    return {1'b1, 8'h00, ata, 8'h00, wp, 2'b00, wr, 1'b1, crc, 2'b01, TASK_IDX};
  endfunction
  always @(posedge sys_clk) begin
    cyc++;
    if (xferStart_q === 1'b1)
      nStart++;
    if (cyc == 40000) begin
      num_errors++;
      end_sim();
    end
  end
  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    check({cmdOut_q, cmdOe_q, dat2Oe_q}, 3'b100);
    for (int i = 0; i < 7; i++) begin
      bus(5'(i * 4), 1'b0, 32'h0, q);
      check(q, 32'h0);
    end
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b1, rows[i].w, q);
      bus(rows[i].a, 1'b0, 32'h0, q);
      check(q, rows[i].e);
    end
    // ask the card whether it can take a stall before raising one
    bus(OFF_ARGUMENT, 1'b1, IO_ARG, q);
    bus(OFF_COMMAND, 1'b1, IO_CMD, q);
    waitBit(ST_DONE);
    bus(OFF_RESPONSE, 1'b0, 32'h0, q);
    check(q[2], 1'b1);
    bus(OFF_STATUS, 1'b1, 32'h0000_0007, q);
    bus(OFF_CONTROL, 1'b1, 32'h1, q);
    repeat (2) @(posedge sys_clk);
    check({dat2Oe_q, dat2Out_q}, 2'b10);
    bus(OFF_STATUS, 1'b0, 32'h0, q);
    check(q[ST_STALLING], 1'b1);
    bus(OFF_CONTROL, 1'b1, 32'h0, q);
    repeat (2) @(posedge sys_clk);
    check(dat2Oe_q, 1'b0);
    // task file write, waiting on previous data with none pending
    bus(OFF_BLOCK_LEN, 1'b1, 32'h0000_0010, q);
    bus(OFF_XFER_LEN, 1'b1, 32'h0000_0010, q);
    bus(OFF_ARGUMENT, 1'b1, TF_ARG, q);
    bus(OFF_COMMAND, 1'b1, cmdWord(1'b1, 1'b0, 1'b1, 1'b1), q);
    waitBit(ST_DONE);
    repeat (2) @(posedge sys_clk);
    check(lastCmd[47:8], {CMD_PREFIX, TASK_IDX, TF_ARG});
    check(lastCmd[7:0], {i_card.crc7(lastCmd[47:8]), 1'b1});
    bus(OFF_RESPONSE, 1'b0, 32'h0, q);
    check(q, TF_ARG);
    check(nStart, 1);
    check({xferWrite_q, xferReadAta_q, xferSingle_q}, 3'b101);
    check(xferBlockLen_q, 16'h0010);
    check(xferBytes_q, 32'h0000_0010);
    bus(OFF_COMMAND, 1'b0, 32'h0, q);
    check(q[CMD_START], 1'b0);
    // task file read held back by the pending data transfer
    bus(OFF_STATUS, 1'b1, 32'h0000_0007, q);
    bus(OFF_STATUS, 1'b0, 32'h0, q);
    check(q[ST_DATA_PEND], 1'b1);
    c2 = cmdWord(1'b0, 1'b1, 1'b1, 1'b1);
    bus(OFF_ARGUMENT, 1'b1, 32'h0000_0010, q);
    bus(OFF_COMMAND, 1'b1, c2, q);
    repeat (40) @(posedge sys_clk);
    check(cmdOe_q, 1'b0);
    bus(OFF_COMMAND, 1'b1, 32'h0, q);
    bus(OFF_COMMAND, 1'b0, 32'h0, q);
    check(q, c2);
    @(posedge sys_clk);
    dataOver <= 1'b1;
    @(posedge sys_clk);
    dataOver <= 1'b0;
    waitBit(ST_DONE);
    repeat (2) @(posedge sys_clk);
    check({xferWrite_q, xferReadAta_q, 6'(nStart)}, {2'b01, 6'd2});
    // corrupted response crc, checked and then unchecked
    bus(OFF_STATUS, 1'b1, 32'h0000_0007, q);
    badCrc <= 1'b1;
    bus(OFF_COMMAND, 1'b1, cmdWord(1'b1, 1'b0, 1'b1, 1'b0), q);
    waitBit(ST_CRC_ERR);
    repeat (4) @(posedge sys_clk);
    check(nStart, 2);
    bus(OFF_STATUS, 1'b1, 32'h0000_0007, q);
    bus(OFF_COMMAND, 1'b1, cmdWord(1'b1, 1'b0, 1'b0, 1'b0), q);
    waitBit(ST_DONE);
    repeat (2) @(posedge sys_clk);
    check({q[ST_CRC_ERR], 6'(nStart)}, {1'b0, 6'd3});
    // silent card: timeout and no transfer start
    badCrc <= 1'b0;
    mute <= 1'b1;
    bus(OFF_STATUS, 1'b1, 32'h0000_0007, q);
    bus(OFF_COMMAND, 1'b1, cmdWord(1'b1, 1'b0, 1'b1, 1'b0), q);
    waitBit(ST_TIMEOUT);
    check(nStart, 3);
    // reset in mid-stall drops the stall line
    mute <= 1'b0;
    bus(OFF_CONTROL, 1'b1, 32'h1, q);
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    check(dat2Oe_q, 1'b0);
    bus(OFF_CONTROL, 1'b0, 32'h0, q);
    check(q, 32'h0);
    end_sim();
  end
endmodule
